// ===== verilog/vdr_pkg.sv
// Package for the bus slave dynamic RAM board controller.
// Assumes a 250 MHz core clock and pins already at logic levels.
package vdr_pkg;

  // Clock and refresh timing
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned REF_OSC_KHZ     = 64;
  localparam int unsigned REF_TICK_CYC    = (CLK_MHZ * 1000) / REF_OSC_KHZ;
  localparam int unsigned REF_PERIOD_US   = 15;
  localparam int unsigned REF_CYC         = REF_PERIOD_US * CLK_MHZ;
  localparam logic [7:0]  REF_BUSY_CYC    = 8'h10;
  localparam logic [7:0]  MEM_ACCESS_CYC  = 8'h0c;

  // Array geometry
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned ROW_W           = 18;
  localparam int unsigned MUX_W           = 9;
  localparam int unsigned NUM_ROWS        = 4;
  localparam logic [1:0]  REF_TICK_RST    = 2'h0;

  // Parity mode option
  typedef enum logic [1:0] {
    VDR_PAR_OFF   = 2'b00,
    VDR_PAR_ON    = 2'b01,
    VDR_PAR_FORCE = 2'b10
  } vdr_par_mode_e;

  // Parity byte option
  typedef enum logic [1:0] {
    VDR_PB_LOW  = 2'b01,
    VDR_PB_HIGH = 2'b10,
    VDR_PB_BOTH = 2'b11
  } vdr_par_byte_e;

  // Board configuration straps
  typedef struct packed {
    logic [4:0]    base_addr;
    logic          big_dev;
    logic          ilv_en;
    logic          ilv_odd;
    vdr_par_mode_e par_mode;
    vdr_par_byte_e par_byte;
  } vdr_cfg_s;

  // Bus request signals after synchronisation
  typedef struct packed {
    logic [23:1] addr;
    logic [5:0]  am;
    logic        iack_n;
    logic        lword_n;
    logic        write_n;
    logic [1:0]  ds_n;
    logic        as_n;
  } vdr_bus_s;

  // Memory array strobes
  typedef struct packed {
    logic [NUM_ROWS-1:0] ras_n;
    logic [1:0]          cas_n;
    logic                we_n;
    logic [MUX_W-1:0]    maddr;
  } vdr_dram_s;

endpackage : vdr_pkg

// ===== verilog/vdr_ctrl.sv
// Controller: decode, arbitration, refresh, parity and acknowledge.
// Assumes bus inputs come from another domain; the array answers
// read data within MEM_ACCESS_CYC cycles of its column strobe.
`timescale 1ns/1ps

module vdr_ctrl (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Configuration straps
  input  wire vdr_pkg::vdr_cfg_s          cfg,
  input  wire logic [63:0]                am_allow,
  // Bus side
  input  wire vdr_pkg::vdr_bus_s          bus_in,
  input  wire logic [15:0]                bus_wdata,
  output logic [15:0]                     bus_rdata,
  output logic                            bus_rdata_oe,
  output logic                            dtack_n,
  output logic                            berr_n,
  // Memory array
  output vdr_pkg::vdr_dram_s              dram,
  output logic [vdr_pkg::ROW_W-1:0]       mem_wdata,
  input  wire logic [vdr_pkg::ROW_W-1:0]  mem_rdata,
  // Indicators
  output logic                            busy_led,
  output logic                            par_err_led
);

  typedef enum logic [2:0] {
    VDR_IDLE  = 3'b000,
    VDR_REF   = 3'b001,
    VDR_ROW   = 3'b010,
    VDR_COL   = 3'b011,
    VDR_DONE  = 3'b100,
    VDR_HOLD  = 3'b101
  } vdr_state_e;

  // Two-flop synchronisers for all bus pins
  localparam int unsigned BUS_W = $bits(vdr_pkg::vdr_bus_s) + vdr_pkg::DATA_W;
  logic [BUS_W-1:0] sync1_q;
  logic [BUS_W-1:0] sync2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= {bus_in, bus_wdata};
      sync2_q <= sync1_q;
    end
  end

  vdr_pkg::vdr_bus_s bs;
  logic [15:0]       wd_s;
  assign bs   = vdr_pkg::vdr_bus_s'(sync2_q[BUS_W-1:vdr_pkg::DATA_W]);
  assign wd_s = sync2_q[vdr_pkg::DATA_W-1:0];

  // Address decode
  wire        strobe_act = !bs.as_n && (bs.ds_n != 2'b11);
  wire [6:0]  am_idx     = {bs.iack_n, bs.am};
  wire        local_sel  = am_allow[am_idx[5:0]] && bs.iack_n && bs.lword_n;
  // Base match over A19-A23; 512K board gives one of 32 slots
  wire        base_hit   = (bs.addr[23:19] == cfg.base_addr);
  wire        word_hit   = !cfg.ilv_en || (bs.addr[1] == cfg.ilv_odd);
  wire        addr_sel   = base_hit && word_hit;
  wire        board_sel  = local_sel && addr_sel && strobe_act;

  // Latched request
  logic [23:1] addr_q;
  logic [15:0] wdata_q;
  logic        wr_q;
  logic [1:0]  ds_q;

  // Row and column split
  wire [1:0] row_idx = cfg.big_dev ? addr_q[21:20] : addr_q[19:18];
  wire [8:0] row_adr = {cfg.big_dev & addr_q[19], addr_q[17:10]};
  wire [8:0] col_adr = {1'b0, addr_q[9:2]};

  // Parity
  wire par_en     = (cfg.par_mode != vdr_pkg::VDR_PAR_OFF);
  wire par_force  = (cfg.par_mode == vdr_pkg::VDR_PAR_FORCE);
  wire gen_lo     = ~^wdata_q[7:0] ^ par_force;
  wire gen_hi     = ~^wdata_q[15:8] ^ par_force;
  wire chk_lo_bad = (^mem_rdata[7:0] ^ mem_rdata[16]) != 1'b1;
  wire chk_hi_bad = (^mem_rdata[15:8] ^ mem_rdata[17]) != 1'b1;
  wire use_lo     = par_en && cfg.par_byte[0] && !ds_q[0];
  wire use_hi     = par_en && cfg.par_byte[1] && !ds_q[1];
  wire rd_bad     = (use_lo && chk_lo_bad) || (use_hi && chk_hi_bad);

  // Refresh tick, free running regardless of bus traffic
  logic [15:0] tick_cnt_q;
  logic        ref_pend_q;
  wire         tick = (tick_cnt_q == 16'(vdr_pkg::REF_TICK_CYC - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 16'h0001;
  end

  vdr_state_e  state_q;
  vdr_state_e  state_d;
  logic [7:0]  tmr_q;
  logic        ack_q;
  logic        err_q;
  logic        ref_cnt_rst;

  // Arbiter: refresh wins only when idle; a pending access then waits
  wire tmr_done = (tmr_q == 8'h00);
  wire start_ref = ref_pend_q;
  wire req_new   = board_sel && !ack_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      VDR_IDLE: begin
        if (start_ref)
          state_d = VDR_REF;
        else if (req_new)
          state_d = VDR_ROW;
      end
      VDR_REF:  if (tmr_done) state_d = VDR_IDLE;
      VDR_ROW:  state_d = VDR_COL;
      VDR_COL:  if (tmr_done) state_d = VDR_DONE;
      VDR_DONE: state_d = VDR_HOLD;
      // A written-ahead master may already be strobing its next cycle here
      VDR_HOLD: if (!strobe_act || !ack_q) state_d = VDR_IDLE;
      default:  state_d = VDR_IDLE;
    endcase
  end

  assign ref_cnt_rst = (state_q == VDR_IDLE) && (state_d == VDR_REF);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ref_pend_q <= 1'b0;
    else if (tick)
      ref_pend_q <= 1'b1;
    else if (ref_cnt_rst)
      ref_pend_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= VDR_IDLE;
      tmr_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      if (ref_cnt_rst)
        tmr_q <= vdr_pkg::REF_BUSY_CYC;
      else if (state_q == VDR_ROW)
        tmr_q <= vdr_pkg::MEM_ACCESS_CYC;
      else if (!tmr_done)
        tmr_q <= tmr_q - 8'h01;
    end
  end

  // Latch address and data at acceptance so the bus side is freed
  wire take = (state_q == VDR_IDLE) && !start_ref && req_new;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q  <= '0;
      wdata_q <= '0;
      wr_q    <= 1'b0;
      ds_q    <= 2'b11;
    end else if (take) begin
      addr_q  <= bs.addr;
      wdata_q <= wd_s;
      wr_q    <= !bs.write_n;
      ds_q    <= bs.ds_n;
    end
  end

  // Write acknowledge comes right after latching; array finishes alone
  wire wr_early = (state_q == VDR_ROW) && wr_q;
  wire rd_fin   = (state_q == VDR_DONE) && !wr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q     <= 1'b0;
      err_q     <= 1'b0;
      bus_rdata <= '0;
    end else if (wr_early) begin
      ack_q <= 1'b1;
    end else if (rd_fin) begin
      ack_q     <= 1'b1;
      err_q     <= rd_bad;
      bus_rdata <= mem_rdata[15:0];
    end else if (!strobe_act) begin
      // Early write ack can be released while the array is still busy
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  // Error light stays until a clean checked read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      par_err_led <= 1'b0;
    else if (rd_fin && rd_bad)
      par_err_led <= 1'b1;
    else if (rd_fin && (use_lo || use_hi))
      par_err_led <= 1'b0;
  end

  assign dtack_n      = !(ack_q && !err_q);
  assign berr_n       = !(ack_q && err_q);
  assign bus_rdata_oe = ack_q && !wr_q && !err_q;
  assign busy_led     = board_sel;

  // Array strobes; refresh is RAS-only to all rows
  wire in_ref = (state_q == VDR_REF);
  wire in_acc = (state_q == VDR_ROW) || (state_q == VDR_COL);
  wire in_col = (state_q == VDR_COL);

  logic [vdr_pkg::NUM_ROWS-1:0] ras_n_c;

  always_comb begin
    ras_n_c = '1;
    if (in_ref)
      ras_n_c = '0;
    else if (in_acc)
      ras_n_c[row_idx] = 1'b0;
  end
  assign dram.ras_n = ras_n_c;
  assign dram.cas_n = in_col ? ds_q : 2'b11;
  assign dram.we_n  = !(in_acc && wr_q);
  assign dram.maddr = in_col ? col_adr : (in_ref ? {1'b0, tick_cnt_q[7:0]} : row_adr);
  assign mem_wdata  = {gen_hi, gen_lo, wdata_q};

endmodule // vdr_ctrl

// ===== bench/vdr_mem_model.sv
// Behavioural array of 18-bit rows behind the controller strobes.
// Assumes strobes change on clk; corrupt flips low parity on reads.
`timescale 1ns/1ps
module vdr_mem_model (
  // Clock and control
  input  wire logic              clk,
  input  wire logic              corrupt,
  // Array side
  input  wire vdr_pkg::vdr_dram_s dram,
  input  wire logic [17:0]       mem_wdata,
  output logic [17:0]            mem_rdata
);
  logic [17:0] mem [int];
  logic [17:0] w;
  logic [12:0] row_q;
  logic [3:0]  ras_q;
  logic [1:0]  cas_q;
  int          k;
  assign k = {row_q, dram.maddr};
  always @(posedge clk) begin
    ras_q <= dram.ras_n;
    cas_q <= dram.cas_n;
    if (&ras_q && !(&dram.ras_n)) row_q <= {dram.ras_n, dram.maddr};
    w = mem.exists(k) ? mem[k] : 18'h0;
    if (!dram.we_n && cas_q[0] && !dram.cas_n[0]) w = {w[17], mem_wdata[16], w[15:8], mem_wdata[7:0]};
    if (!dram.we_n && cas_q[1] && !dram.cas_n[1]) w = {mem_wdata[17], w[16], mem_wdata[15:8], w[7:0]};
    if (!dram.we_n && (cas_q & ~dram.cas_n) != 2'h0) mem[k] = w;
    // Released lines toggle so stale data never looks valid
    if (dram.we_n && !(&dram.cas_n)) mem_rdata <= w ^ {1'b0, corrupt, 16'h0};
    else mem_rdata <= ~mem_rdata;
  end
endmodule // vdr_mem_model

// ===== bench/vdr_ctrl_monitor.sv
// Port assertions for the controller.
// Assumes one clock and the async active-low reset.
`timescale 1ns/1ps
module vdr_ctrl_monitor (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire vdr_pkg::vdr_cfg_s cfg,
  input wire vdr_pkg::vdr_bus_s bus_in,
  input wire logic              dtack_n,
  input wire logic              berr_n,
  input wire logic              bus_rdata_oe,
  input wire vdr_pkg::vdr_dram_s dram,
  input wire logic [17:0]       mem_wdata,
  input wire logic              busy_led,
  input wire logic              par_err_led
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_one_answer: assert property (dtack_n || berr_n)
    else $error("both answers low");
  chk_ans_hold: assert property (!dtack_n && bus_in.as_n |-> ##[1:4] dtack_n)
    else $error("answer not released");
  chk_ack_cause: assert property ($fell(dtack_n) |-> !$past(bus_in.as_n, 2))
    else $error("answer without strobe");
  chk_rd_drive: assert property (bus_rdata_oe |-> !dtack_n && berr_n)
    else $error("data driven without ack");
  chk_par_gen: assert property (!dram.we_n && !dram.cas_n[0] && cfg.par_byte[0]
    && cfg.par_mode == vdr_pkg::VDR_PAR_ON |-> mem_wdata[16] == ~^mem_wdata[7:0])
    else $error("bad low parity");
  chk_par_force: assert property (!dram.we_n && !dram.cas_n[0] && cfg.par_byte[0]
    && cfg.par_mode == vdr_pkg::VDR_PAR_FORCE |-> mem_wdata[16] == ^mem_wdata[7:0])
    else $error("forced parity not wrong");
  chk_err_led: assert property ($fell(berr_n) |-> ##[0:2] par_err_led)
    else $error("error light off");
  chk_wr_quick: assert property ($rose(busy_led) && !bus_in.write_n && !cfg.ilv_en
    |-> ##[1:24] !dtack_n) else $error("write ack late");
  chk_rd_arb: assert property ($rose(busy_led) && bus_in.write_n && !cfg.ilv_en
    |-> ##[8:45] !(dtack_n && berr_n)) else $error("read answer late");
endmodule // vdr_ctrl_monitor
bind vdr_ctrl vdr_ctrl_monitor vdr_ctrl_monitor_i (.clk(clk), .rst_n(rst_n), .cfg(cfg),
  .bus_in(bus_in), .dtack_n(dtack_n), .berr_n(berr_n), .bus_rdata_oe(bus_rdata_oe),
  .dram(dram), .mem_wdata(mem_wdata), .busy_led(busy_led), .par_err_led(par_err_led));

// ===== bench/testbench.sv
// Self-checking bench for the controller with an array model.
// Assumes 250 MHz clock; bus pins change 1 ns after the edge.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk, rst_n, dtack_n, berr_n, oe, busy_led, par_err_led, corrupt;
  logic [15:0] bus_wdata, bus_rdata, q;
  logic [17:0] mem_wdata, mem_rdata;
  logic [1:0]  ans;
  logic [4:0]  bad_base = 5'h00;
  vdr_pkg::vdr_cfg_s  cfg;
  vdr_pkg::vdr_bus_s  bus_in;
  vdr_pkg::vdr_dram_s dram;
  int fail_count, comparisons, cycles;
  vdr_ctrl vdr_ctrl_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .am_allow(64'h1 << 6'h39),
    .bus_in(bus_in), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdata_oe(oe),
    .dtack_n(dtack_n), .berr_n(berr_n), .dram(dram), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .busy_led(busy_led), .par_err_led(par_err_led));
  vdr_mem_model vdr_mem_model_i (.clk(clk), .corrupt(corrupt), .dram(dram),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic summarize;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cycles == 40000) begin
    fail_count++;
    summarize();
  end
  // One bus cycle; strobes held until an answer or 60 edges pass
  task automatic cyc(input logic [17:0] off, input logic w, input logic [1:0] ds,
                     input logic [15:0] d);
    bus_in.addr = {cfg.base_addr ^ bad_base, off};
    bus_in.write_n = ~w;
    bus_wdata = d;
    bus_in.as_n = 0;
    bus_in.ds_n = ~ds;
    repeat (60) begin
      @(posedge clk);
      if (!dtack_n || !berr_n) break;
    end
    ans = {~berr_n, ~dtack_n};
    q = bus_rdata;
    #1;
    bus_in.as_n = 1;
    bus_in.ds_n = 2'h3;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic t_rows;
    for (int i = 0; i < 4; i++) cyc({i[1:0], 16'h0040}, 1, 2'h3, 16'ha5c3 + i);
    for (int i = 0; i < 4; i++) begin
      cyc({i[1:0], 16'h0040}, 0, 2'h3, 16'h0);
      `CHK("row data", 16'ha5c3 + i, q)
    end
    cyc(18'h100, 1, 2'h3, 16'hffff);
    cyc(18'h100, 1, 2'h1, 16'h005a);
    cyc(18'h100, 0, 2'h3, 16'h0);
    `CHK("byte data", 16'hff5a, q)
  endtask
  task automatic t_refuse;
    bad_base = 5'h01;
    cyc(18'h100, 0, 2'h3, 16'h0);
    `CHK("bad base", 2'h0, ans)
    bad_base = 5'h00;
    bus_in.am = 6'h3d;
    cyc(18'h100, 0, 2'h3, 16'h0);
    `CHK("bad code", 2'h0, ans)
    bus_in.am = 6'h39;
    bus_in.iack_n = 0;
    cyc(18'h100, 0, 2'h3, 16'h0);
    `CHK("iack", 2'h0, ans)
    bus_in.iack_n = 1;
    cfg.ilv_en = 1;
    cfg.ilv_odd = 1;
    cyc(18'h100, 1, 2'h3, 16'h0);
    `CHK("even word", 2'h0, ans)
    cyc(18'h101, 1, 2'h3, 16'h0);
    `CHK("odd word", 2'h1, ans)
    cfg.ilv_en = 0;
  endtask
  task automatic t_parity;
    cyc(18'h200, 1, 2'h3, 16'h1357);
    corrupt = 1;
    cyc(18'h200, 0, 2'h3, 16'h0);
    `CHK("bad read", 3'h6, {par_err_led, ans})
    cfg.par_byte = vdr_pkg::VDR_PB_HIGH;
    cyc(18'h200, 0, 2'h3, 16'h0);
    `CHK("high only", 2'h1, ans)
    cfg.par_byte = vdr_pkg::VDR_PB_BOTH;
    cfg.par_mode = vdr_pkg::VDR_PAR_OFF;
    cyc(18'h200, 0, 2'h3, 16'h0);
    `CHK("check off", 2'h1, ans)
    corrupt = 0;
    cfg.par_mode = vdr_pkg::VDR_PAR_ON;
    cyc(18'h200, 0, 2'h3, 16'h0);
    `CHK("clean read", 3'h1, {par_err_led, ans})
    cfg.par_mode = vdr_pkg::VDR_PAR_FORCE;
    cyc(18'h200, 1, 2'h1, 16'h0001);
    cfg.par_mode = vdr_pkg::VDR_PAR_ON;
    cyc(18'h200, 0, 2'h3, 16'h0);
    `CHK("forced", 2'h2, ans)
  endtask
  // Long enough to collide with at least one refresh tick
  task automatic t_refresh;
    for (int i = 0; i < 150; i++) begin
      cyc(18'h300 + i, 1, 2'h3, 16'h7000 + i);
      cyc(18'h300 + i, 0, 2'h3, 16'h0);
      `CHK("refresh data", 16'h7000 + i, q)
    end
  endtask
  initial begin
    rst_n = 0;
    corrupt = 0;
    bus_wdata = 16'h0;
    cfg = '{5'h03, 1'b0, 1'b0, 1'b0, vdr_pkg::VDR_PAR_ON, vdr_pkg::VDR_PB_BOTH};
    bus_in = '{23'h0, 6'h39, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1};
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    #1;
    t_rows();
    t_refuse();
    t_parity();
    t_refresh();
    summarize();
  end
endmodule // testbench
